// File: acq_timing.sv
// Acquisition timing fabric: counter groups, scanning, interval and output update
// How it works
// [RULE_01] Two output channels; each 12-bit code built from low and high byte writes.
// [RULE_02] With deferred update clear, a data write changes the output at once.
// [RULE_03] With deferred update set, output waits for A2 or external strobe falling edge.
// [RULE_04] Unipolar code zero is lowest; bipolar code F800 is most negative.
// [RULE_05] Two groups, each three 16-bit down-counters plus one 8-bit mode register.
// [RULE_06] Group A paces acquisition; group B is free for host timing.
// [RULE_07] A0 runs from 1 MHz tick or from B0 output; B0 runs from 2 MHz.
// [RULE_08] B0 as A0 timebase allows acquisition periods beyond 65,536 microseconds.
// [RULE_09] Interval scanning clocks B1 with the same signal that clocks A0.
// [RULE_10] In interval scanning, B1 output starts each scan sequence.
// [RULE_11] Outside world supplies the clocks of B1 and B2 through the connector.
// [RULE_12] Single-channel interval: 8-bit count of samples, wait interval, repeat.
// [RULE_13] Acquisition ends when sample counter A1 reaches zero.
// [RULE_14] Every counter has clock, gate and output, numbered 0 to 2.
// [RULE_15] Scan steps channel down from highest to 0, then restarts; two to eight.
// [RULE_16] Deferred codes wait in a holding register until the update edge.
module acq_timing (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Counter programming
   input  wire logic        cnt_load,
   input  wire logic        cnt_load_group_b,
   input  wire logic [1:0]  cnt_load_index,
   input  wire logic [15:0] cnt_load_value,
   input  wire logic        mode_write,
   input  wire logic        mode_write_group_b,
   input  wire logic [7:0]  mode_byte,
   // Acquisition control
   input  wire logic        acq_start,
   input  wire logic        timebase_from_b0,
   input  wire logic        interval_mode,
   input  wire logic        scan_enable,
   input  wire logic [2:0]  scan_high_channel,
   input  wire logic        interval_count_load,
   input  wire logic [7:0]  interval_count_value,
   // Group B connector pins
   input  wire logic [2:0]  group_b_gate_pin,
   input  wire logic        group_b_counter1_clock_pin,
   input  wire logic        group_b_counter2_clock_pin,
   // Analog output writes
   input  wire logic [1:0]  dac_wr_low,
   input  wire logic [1:0]  dac_wr_high,
   input  wire logic [7:0]  dac_wr_data,
   input  wire logic        deferred_update_select,
   input  wire logic [1:0]  dac_bipolar,
   input  wire logic        external_update_strobe_n,
   // Outputs
   output logic [2:0]       group_a_out,
   output logic [2:0]       group_b_out,
   output logic             scan_interval_output,
   output logic             group_a_counter0_clock,
   output logic             sample_strobe,
   output logic             acq_active_q,
   output logic [2:0]       channel_q,
   output logic [11:0]      analog_out_channel0_code,
   output logic [11:0]      analog_out_channel1_code
);
   localparam int unsigned N_CNT = 6;
   localparam int          DIV_A_GAP = acq_timing_pkg::DIV_A_CYCLES;

   logic [4:0]  div_a_q;
   logic [4:0]  div_b_q;
   logic        tick_1mhz;
   logic        tick_2mhz;
   logic [7:0]  mode_a_q;
   logic [7:0]  mode_b_q;
   logic [1:0]  clk1_s1_q;
   logic [1:0]  clk1_s2_q;
   logic [1:0]  clk1_prev_q;
   logic [2:0]  gate_s1_q;
   logic [2:0]  gate_s2_q;
   logic        upd_s1_q;
   logic        upd_s2_q;
   logic        upd_prev_q;
   logic        b0_prev_q;
   logic        a2_prev_q;
   logic        burst_q;
   logic [7:0]  ivl_load_q;
   logic [7:0]  ivl_cnt_q;
   logic        update_pulse;
   logic        b0_rise;
   logic [N_CNT-1:0] tick;
   logic [N_CNT-1:0] gate;
   logic [N_CNT-1:0] one_shot;
   logic [N_CNT-1:0] load;
   logic [N_CNT-1:0] outs;
   logic [N_CNT-1:0] term;

   if (acq_timing_pkg::DIV_A_CYCLES > 31 || acq_timing_pkg::DIV_B_CYCLES < 2) begin : g_bad_div
      $error("timebase dividers out of range");
   end

   // Timebase dividers from the system clock
   assign tick_1mhz = div_a_q == 5'(acq_timing_pkg::DIV_A_CYCLES - 1);
   assign tick_2mhz = div_b_q == 5'(acq_timing_pkg::DIV_B_CYCLES - 1);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_a_q <= 5'h00;
         div_b_q <= 5'h00;
      end else begin
         div_a_q <= tick_1mhz ? 5'h00 : div_a_q + 5'h01;
         div_b_q <= tick_2mhz ? 5'h00 : div_b_q + 5'h01;
      end
   end

   // Synchronisers for connector pins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         clk1_s1_q   <= 2'h0;
         clk1_s2_q   <= 2'h0;
         clk1_prev_q <= 2'h0;
         gate_s1_q   <= 3'h0;
         gate_s2_q   <= 3'h0;
         upd_s1_q    <= 1'b1;
         upd_s2_q    <= 1'b1;
         upd_prev_q  <= 1'b1;
      end else begin
         clk1_s1_q   <= {group_b_counter2_clock_pin, group_b_counter1_clock_pin}; // [RULE_11]
         clk1_s2_q   <= clk1_s1_q;
         clk1_prev_q <= clk1_s2_q;
         gate_s1_q   <= group_b_gate_pin;
         gate_s2_q   <= gate_s1_q;
         upd_s1_q    <= external_update_strobe_n;
         upd_s2_q    <= upd_s1_q;
         upd_prev_q  <= upd_s2_q;
      end
   end

   // Mode registers, one byte per group
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mode_a_q <= acq_timing_pkg::MODE_RESET;
         mode_b_q <= acq_timing_pkg::MODE_RESET;
      end else if (mode_write) begin
         if (mode_write_group_b)
            mode_b_q <= mode_byte; // [RULE_05]
         else
            mode_a_q <= mode_byte; // [RULE_05]
      end
   end

   // Counter clock selection
   assign b0_rise = outs[3] && !b0_prev_q;
   assign group_a_counter0_clock = timebase_from_b0 ? b0_rise : tick_1mhz; // [RULE_07] [RULE_08]

   always_comb begin
      tick[0] = group_a_counter0_clock;
      tick[1] = sample_strobe; // [RULE_13]
      tick[2] = tick_1mhz;
      tick[3] = tick_2mhz; // [RULE_07]
      tick[4] = interval_mode ? group_a_counter0_clock // [RULE_09]
                              : clk1_s2_q[0] && !clk1_prev_q[0];
      tick[5] = clk1_s2_q[1] && !clk1_prev_q[1];
      gate[0] = acq_active_q; // [RULE_06]
      gate[1] = acq_active_q;
      gate[2] = 1'b1;
      gate[5:3] = gate_s2_q; // [RULE_14]
      one_shot = {mode_b_q[acq_timing_pkg::MODE_ONE_SHOT_POS +: 3],
                  mode_a_q[acq_timing_pkg::MODE_ONE_SHOT_POS +: 3]};
      load = '0;
      if (cnt_load && cnt_load_index != 2'h3)
         load[(cnt_load_group_b ? acq_timing_pkg::GRP_B_BASE : 0) + cnt_load_index] = 1'b1;
   end

   // Six counters, A0..A2 then B0..B2
   for (genvar i = 0; i < N_CNT; i++) begin : g_cnt
      down_counter #(.WIDTH(acq_timing_pkg::CNT_W)) u_cnt (
         .clk        (clk),
         .reset      (reset),
         .tick       (tick[i]),
         .gate       (gate[i]),
         .one_shot   (one_shot[i]),
         .load       (load[i]),
         .load_value (cnt_load_value),
         .count_q    (),
         .out_q      (outs[i]),
         .terminal   (term[i])
      ); // [RULE_05] [RULE_14]
   end

   assign group_a_out = outs[2:0];
   assign group_b_out = outs[5:3];
   assign scan_interval_output = outs[4];

   // Sample pacing: A0 terminal counts, gated by the interval burst
   assign sample_strobe = acq_active_q && term[0] && (!interval_mode || burst_q);

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         acq_active_q <= 1'b0;
      else if (term[1])
         acq_active_q <= 1'b0; // [RULE_13]
      else if (acq_start)
         acq_active_q <= 1'b1;
   end

   // Interval bursts started by B1
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         ivl_load_q <= 8'h00;
      else if (interval_count_load)
         ivl_load_q <= interval_count_value; // [RULE_12]
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         burst_q   <= 1'b0;
         ivl_cnt_q <= 8'h00;
      end else if (!acq_active_q || !interval_mode) begin
         burst_q   <= 1'b0;
         ivl_cnt_q <= ivl_load_q;
      end else if (term[4]) begin
         burst_q   <= 1'b1; // [RULE_10]
         ivl_cnt_q <= ivl_load_q; // [RULE_12]
      end else if (sample_strobe) begin
         if (scan_enable) begin
            if (channel_q == 3'h0)
               burst_q <= 1'b0; // [RULE_10]
         end else begin
            ivl_cnt_q <= ivl_cnt_q - 8'h01;
            if (ivl_cnt_q <= 8'h01)
               burst_q <= 1'b0; // [RULE_12]
         end
      end
   end

   // Scan counter steps downward and wraps to the highest channel
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         channel_q <= 3'h0;
      else if (!scan_enable || !acq_active_q)
         channel_q <= scan_enable ? scan_high_channel : 3'h0;
      else if (sample_strobe)
         channel_q <= (channel_q == 3'h0) ? scan_high_channel : channel_q - 3'h1; // [RULE_15]
   end

   // B0 edge for the A0 timebase, A2 update edge for the deferred path
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         b0_prev_q <= 1'b1;
         a2_prev_q <= 1'b1;
      end else begin
         b0_prev_q <= outs[3];
         a2_prev_q <= outs[2];
      end
   end

   assign update_pulse = (a2_prev_q && !outs[2]) || (upd_prev_q && !upd_s2_q); // [RULE_03]

   dac_channel u_analog_out_channel0_code (
      .clk                    (clk),
      .reset                  (reset),
      .wr_low                 (dac_wr_low[0]),
      .wr_high                (dac_wr_high[0]),
      .wr_data                (dac_wr_data),
      .deferred_update_select (deferred_update_select),
      .update_pulse           (update_pulse),
      .bipolar                (dac_bipolar[0]),
      .code_q                 (analog_out_channel0_code)
   ); // [RULE_01]

   dac_channel u_analog_out_channel1_code (
      .clk                    (clk),
      .reset                  (reset),
      .wr_low                 (dac_wr_low[1]),
      .wr_high                (dac_wr_high[1]),
      .wr_data                (dac_wr_data),
      .deferred_update_select (deferred_update_select),
      .update_pulse           (update_pulse),
      .bipolar                (dac_bipolar[1]),
      .code_q                 (analog_out_channel1_code)
   ); // [RULE_01]

   // Checks
   sequence s_scan_wrap;
      scan_enable && acq_active_q && sample_strobe && channel_q == 3'h0;
   endsequence
   sequence s_scan_step;
      scan_enable && acq_active_q && sample_strobe && channel_q != 3'h0;
   endsequence

   a_acq_end_stop: assert property (@(posedge clk) disable iff (reset) // [RULE_13]
      term[1] |=> !acq_active_q)
      else $error("acquisition did not stop at zero sample count");
   a_scan_wrap: assert property (@(posedge clk) disable iff (reset) // [RULE_15]
      s_scan_wrap ##1 scan_enable && acq_active_q |-> channel_q == $past(scan_high_channel))
      else $error("scan did not restart at highest channel");
   a_scan_step: assert property (@(posedge clk) disable iff (reset) // [RULE_15]
      s_scan_step ##1 scan_enable && acq_active_q |-> channel_q == $past(channel_q) - 3'h1)
      else $error("scan did not step down");
   a_b1_clock_src: assert property (@(posedge clk) disable iff (reset) // [RULE_09]
      interval_mode |-> tick[4] == group_a_counter0_clock)
      else $error("B1 not clocked with A0");
   a_timebase_sel: assert property (@(posedge clk) disable iff (reset) // [RULE_07]
      !timebase_from_b0 && group_a_counter0_clock |-> ##DIV_A_GAP tick_1mhz)
      else $error("A0 timebase not 1 MHz");
   a_burst_start: assert property (@(posedge clk) disable iff (reset) // [RULE_10]
      acq_active_q && interval_mode && term[4] && !term[1] |=> burst_q)
      else $error("B1 output did not start a scan");
   a_burst_gate: assert property (@(posedge clk) disable iff (reset) // [RULE_12]
      interval_mode && !burst_q |-> !sample_strobe)
      else $error("sample taken outside interval burst");
   a_ivl_count_end: assert property (@(posedge clk) disable iff (reset) // [RULE_12]
      interval_mode && !scan_enable && sample_strobe && ivl_cnt_q == 8'h01 && !term[4]
      && acq_active_q |=> !burst_q)
      else $error("interval burst did not end after programmed samples");
   a_update_ext: assert property (@(posedge clk) disable iff (reset) // [RULE_03]
      upd_prev_q && !upd_s2_q |-> update_pulse)
      else $error("external strobe edge missed");
endmodule // acq_timing

// File: acq_timing_and_dac_update_tb.sv
// Self-checking bench for the acquisition timing and analog output update block
module acq_timing_and_dac_update_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int PIN_CLKS = 10;

   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        cnt_load = 1'b0, cnt_load_group_b = 1'b0;
   logic [1:0]  cnt_load_index = 2'h0;
   logic [15:0] cnt_load_value = 16'h0000;
   logic        mode_write = 1'b0, mode_write_group_b = 1'b0;
   logic [7:0]  mode_byte = 8'h00;
   logic        acq_start = 1'b0, timebase_from_b0 = 1'b0, interval_mode = 1'b0;
   logic        scan_enable = 1'b0, interval_count_load = 1'b0;
   logic [2:0]  scan_high_channel = 3'h1;
   logic [7:0]  interval_count_value = 8'h00;
   logic [2:0]  gate_pin;
   logic        b1_pin, b2_pin, update_n;
   logic [1:0]  dac_wr_low = 2'h0, dac_wr_high = 2'h0, dac_bipolar = 2'h0;
   logic [7:0]  dac_wr_data = 8'h00;
   logic        deferred_update_select = 1'b0;
   logic [2:0]  group_a_out, group_b_out, channel_q;
   logic        scan_interval_output, group_a_counter0_clock, sample_strobe, acq_active_q;
   logic [11:0] code0, code1;
   logic [11:0] hold [2];
   logic [11:0] lat [2];
   logic [2:0]  exp_chan [$];
   int          n_mismatch = 0;
   int          comparisons = 0;
   int          n_samples = 0;

   always #20 clk = ~clk;

   far_side_model #(.PIN_HALF_NS(PIN_CLKS * 20)) u_far (
      .group_b_gate_pin           (gate_pin),
      .group_b_counter1_clock_pin (b1_pin),
      .group_b_counter2_clock_pin (b2_pin),
      .external_update_strobe_n   (update_n)
   );

   acq_timing DUT (
      .clk(clk), .reset(reset),
      .cnt_load(cnt_load), .cnt_load_group_b(cnt_load_group_b),
      .cnt_load_index(cnt_load_index), .cnt_load_value(cnt_load_value),
      .mode_write(mode_write), .mode_write_group_b(mode_write_group_b), .mode_byte(mode_byte),
      .acq_start(acq_start), .timebase_from_b0(timebase_from_b0),
      .interval_mode(interval_mode), .scan_enable(scan_enable),
      .scan_high_channel(scan_high_channel), .interval_count_load(interval_count_load),
      .interval_count_value(interval_count_value), .group_b_gate_pin(gate_pin),
      .group_b_counter1_clock_pin(b1_pin), .group_b_counter2_clock_pin(b2_pin),
      .dac_wr_low(dac_wr_low), .dac_wr_high(dac_wr_high), .dac_wr_data(dac_wr_data),
      .deferred_update_select(deferred_update_select), .dac_bipolar(dac_bipolar),
      .external_update_strobe_n(update_n),
      .group_a_out(group_a_out), .group_b_out(group_b_out),
      .scan_interval_output(scan_interval_output),
      .group_a_counter0_clock(group_a_counter0_clock), .sample_strobe(sample_strobe),
      .acq_active_q(acq_active_q), .channel_q(channel_q),
      .analog_out_channel0_code(code0), .analog_out_channel1_code(code1)
   );

   task automatic check_vec(string name, logic [15:0] exp, logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   task automatic check_int(string name, int exp, int got);
      comparisons++;
      if (got != exp) begin
         n_mismatch++;
         $display("unexpected %s expected %0d seen %0d", name, exp, got);
      end
   endtask

   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Sample strobes: oldest noted channel against the one presented
   always @(posedge clk) begin
      if (sample_strobe === 1'b1) begin
         n_samples++;
         if (exp_chan.size() > 0) check_vec("channel", 16'(exp_chan.pop_front()), 16'(channel_q));
      end
   end

   task automatic load_cnt(logic grp_b, logic [1:0] idx, logic [15:0] v);
      cnt_load = 1'b1;
      cnt_load_group_b = grp_b;
      cnt_load_index = idx;
      cnt_load_value = v;
      tick(1);
      cnt_load = 1'b0;
      tick(1);
   endtask

   task automatic write_mode(logic grp_b, logic [7:0] m);
      mode_write = 1'b1;
      mode_write_group_b = grp_b;
      mode_byte = m;
      tick(1);
      mode_write = 1'b0;
   endtask

   function automatic logic [11:0] view(int ch);
      return hold[ch] ^ (dac_bipolar[ch] ? acq_timing_pkg::BIPOLAR_OFFSET : 12'h000);
   endfunction

   task automatic dac_write(int ch, logic hi, logic [7:0] d);
      dac_wr_data = d;
      if (hi) dac_wr_high[ch] = 1'b1;
      else dac_wr_low[ch] = 1'b1;
      tick(1);
      dac_wr_low = 2'h0;
      dac_wr_high = 2'h0;
      tick(1);
      if (hi) hold[ch][11:8] = d[3:0];
      else hold[ch][7:0] = d;
      if (!deferred_update_select) lat[ch] = view(ch);
   endtask

   task automatic check_codes();
      check_vec("code0", 16'(lat[0]), 16'(code0));
      check_vec("code1", 16'(lat[1]), 16'(code1));
   endtask

   function automatic logic pick(int sel);
      return (sel == 0) ? group_a_counter0_clock : ~scan_interval_output;
   endfunction

   task automatic wait_rise(int sel, output int n);
      logic p;
      n = 0;
      p = pick(sel);
      while (n < 2000) begin
         @(posedge clk);
         n++;
         if (pick(sel) === 1'b1 && p === 1'b0) break;
         p = pick(sel);
      end
   endtask

   // Period of a repeating event, measured after it has settled
   task automatic gap(string name, int sel, int exp);
      int n;
      wait_rise(sel, n);
      wait_rise(sel, n);
      wait_rise(sel, n);
      #1;
      check_int(name, exp, n);
   endtask

   initial begin
      #(20000 * 40);
      n_mismatch++;
      end_sim();
   end

   initial begin
      int k;
      hold = '{12'h000, 12'h000};
      lat = '{12'h000, 12'h000};
      void'($urandom(32'h285f8d63));
      tick(20);
      reset = 1'b0;
      tick(1);
      check_vec("group_a_out", 16'h0007, 16'(group_a_out));
      check_vec("group_b_out", 16'h0007, 16'(group_b_out));
      check_codes();
      // Immediate update, random bytes on both channels
      dac_bipolar = 2'($urandom);
      for (k = 0; k < 8; k++) begin
         dac_write(k % 2, k[1], 8'($urandom));
         check_codes();
      end
      // Lowest code in each configuration
      dac_bipolar = 2'b10;
      dac_write(0, 1'b0, 8'h00);
      dac_write(0, 1'b1, 8'h00);
      dac_write(1, 1'b0, acq_timing_pkg::BIPOLAR_MIN_CODE[7:0]);
      dac_write(1, 1'b1, acq_timing_pkg::BIPOLAR_MIN_CODE[15:8]);
      check_vec("unipolar_low", 16'h0000, 16'(code0));
      check_vec("bipolar_low", 16'h0000, 16'(code1));
      // Deferred update by external strobe
      write_mode(1'b0, 8'h06);
      load_cnt(1'b0, 2'h2, 16'hffff);
      tick(8);
      deferred_update_select = 1'b1;
      dac_write(0, 1'b0, 8'h5a);
      dac_write(0, 1'b1, 8'h03);
      tick(6);
      check_codes();
      u_far.pulse_update();
      tick(8);
      lat[0] = view(0);
      check_codes();
      // Deferred update by group A counter 2
      dac_write(1, 1'b0, 8'hc3);
      dac_write(1, 1'b1, 8'h0e);
      tick(4);
      check_codes();
      write_mode(1'b0, 8'h02);
      load_cnt(1'b0, 2'h2, 16'h0002);
      tick(80);
      lat[1] = view(1);
      check_codes();
      deferred_update_select = 1'b0;
      // Timebases of group A counter 0
      write_mode(1'b1, 8'h00);
      load_cnt(1'b1, 2'h0, 16'h0004);
      timebase_from_b0 = 1'b1;
      gap("b0_timebase", 0, 4 * acq_timing_pkg::DIV_B_CYCLES);
      timebase_from_b0 = 1'b0;
      gap("1mhz_timebase", 0, acq_timing_pkg::DIV_A_CYCLES);
      // Scan interval counter from A0 clock, then from the connector pin
      interval_count_value = 8'h03;
      interval_count_load = 1'b1;
      tick(1);
      interval_count_load = 1'b0;
      interval_mode = 1'b1;
      load_cnt(1'b1, 2'h1, 16'h0003);
      gap("interval_a0", 1, 3 * acq_timing_pkg::DIV_A_CYCLES);
      interval_mode = 1'b0;
      gap("interval_pin", 1, 3 * PIN_CLKS);
      // Scanned acquisition ending on the sample count
      scan_enable = 1'b1;
      scan_high_channel = 3'h2;
      load_cnt(1'b0, 2'h0, 16'h0002);
      load_cnt(1'b0, 2'h1, 16'h0005);
      tick(2);
      for (k = 0; k < 5; k++) exp_chan.push_back(3'(2 - k % 3));
      n_samples = 0;
      acq_start = 1'b1;
      tick(1);
      acq_start = 1'b0;
      check_vec("acq_active", 16'h0001, 16'(acq_active_q));
      for (k = 0; k < 1000 && acq_active_q !== 1'b0; k++) tick(1);
      tick(30);
      check_int("samples", 5, n_samples);
      // Single-channel interval acquisition in bursts of three
      scan_enable = 1'b0;
      interval_mode = 1'b1;
      load_cnt(1'b1, 2'h1, 16'h000a);
      load_cnt(1'b0, 2'h1, 16'h0006);
      for (k = 0; k < 6; k++) exp_chan.push_back(3'h0);
      acq_start = 1'b1;
      tick(1);
      acq_start = 1'b0;
      wait_rise(1, k);
      n_samples = 0;
      wait_rise(1, k);
      #1;
      check_int("burst_samples", 3, n_samples);
      for (k = 0; k < 1000 && acq_active_q !== 1'b0; k++) tick(1);
      tick(30);
      check_int("interval_samples", 6, n_samples);
      check_int("pending_channels", 0, exp_chan.size());
      end_sim();
   end
endmodule // acq_timing_and_dac_update_tb

// File: acq_timing_pkg.sv
// Shared constants for the acquisition timing and analog output update block
package acq_timing_pkg;
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned OSC_HZ        = 10_000_000;
   localparam int unsigned TB_A_HZ       = 1_000_000;
   localparam int unsigned TB_B_HZ       = 2_000_000;
   localparam int unsigned DIV_A_CYCLES  = CLK_HZ / TB_A_HZ;
   localparam int unsigned DIV_B_CYCLES  = CLK_HZ / TB_B_HZ;
   localparam int unsigned CNT_W         = 16;
   localparam int unsigned DAC_W         = 12;
   localparam int unsigned IVL_W         = 8;
   localparam int unsigned MODE_W        = 8;
   localparam int unsigned CHAN_W        = 3;
   localparam logic [15:0] BIPOLAR_MIN_CODE = 16'hf800;
   localparam logic [11:0] BIPOLAR_OFFSET   = 12'h800;
   localparam logic [7:0]  MODE_RESET       = 8'h00;
   localparam logic [11:0] DAC_RESET        = 12'h000;
   localparam logic [15:0] CNT_RESET        = 16'h0000;
   localparam int unsigned MODE_ONE_SHOT_POS = 0;
   localparam int unsigned DAC_HIGH_POS      = 8;
   localparam int unsigned GRP_B_BASE        = 3;
endpackage

// File: dac_channel.sv
// One analog output channel: byte assembly, holding register and converter latch
module dac_channel (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Host writes
   input  wire logic        wr_low,
   input  wire logic        wr_high,
   input  wire logic [7:0]  wr_data,
   // Update control
   input  wire logic        deferred_update_select,
   input  wire logic        update_pulse,
   input  wire logic        bipolar,
   // Converter latch
   output logic [11:0]      code_q
);
   logic [11:0] hold_q;
   logic [11:0] hold_d;

   // Bipolar F800 and unipolar zero both map to the bottom of the range
   function automatic logic [11:0] to_latch(input logic [11:0] c, input logic bip);
      return bip ? (c ^ acq_timing_pkg::BIPOLAR_OFFSET) : c;
   endfunction

   always_comb begin
      hold_d = hold_q;
      if (wr_low)
         hold_d[7:0] = wr_data;
      if (wr_high)
         hold_d[11:8] = wr_data[3:0];
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         hold_q <= acq_timing_pkg::DAC_RESET;
      else
         hold_q <= hold_d; // [RULE_01] [RULE_16]
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         code_q <= acq_timing_pkg::DAC_RESET;
      else if (!deferred_update_select && (wr_low || wr_high))
         code_q <= to_latch(hold_d, bipolar); // [RULE_02] [RULE_04]
      else if (deferred_update_select && update_pulse)
         code_q <= to_latch(hold_q, bipolar); // [RULE_03] [RULE_16]
   end

   a_immediate_write: assert property (@(posedge clk) disable iff (reset) // [RULE_02]
      !deferred_update_select && wr_low |=> code_q[7:0] == (to_latch(hold_q, bipolar) & 12'h0ff))
      else $error("immediate write not applied");
   a_deferred_hold: assert property (@(posedge clk) disable iff (reset) // [RULE_03]
      deferred_update_select && !update_pulse && $stable(bipolar) |=> $stable(code_q))
      else $error("deferred output changed without update edge");
   a_deferred_load: assert property (@(posedge clk) disable iff (reset) // [RULE_16]
      deferred_update_select && update_pulse |=> code_q == to_latch($past(hold_q), $past(bipolar)))
      else $error("holding register not transferred");
endmodule // dac_channel

// File: down_counter.sv
// One 16-bit down-counter with clock enable, gate and output
module down_counter #(
   parameter int unsigned WIDTH = acq_timing_pkg::CNT_W
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Counting
   input  wire logic             tick,
   input  wire logic             gate,
   input  wire logic             one_shot,
   // Loading
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_value,
   // Results
   output logic      [WIDTH-1:0] count_q,
   output logic                  out_q,
   output logic                  terminal
);
   logic [WIDTH-1:0] reload_q;
   logic             armed_q;

   if (WIDTH < 2) begin : g_bad_width
      $error("down_counter width too small");
   end

   assign terminal = armed_q && tick && gate && (one_shot ? count_q == 1 : count_q <= 1);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count_q  <= '0;
         reload_q <= '0;
         armed_q  <= 1'b0;
      end else if (load) begin
         count_q  <= load_value;
         reload_q <= load_value;
         armed_q  <= 1'b1;
      end else if (armed_q && tick && gate) begin
         if (terminal && !one_shot)
            count_q <= reload_q;
         else if (count_q != 0)
            count_q <= count_q - 1'b1;
         if (terminal && one_shot)
            armed_q <= 1'b0;
      end
   end

   // Rate mode pulses low at terminal; one-shot goes high at zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         out_q <= 1'b1;
      else if (load)
         out_q <= !one_shot;
      else if (terminal)
         out_q <= one_shot;
      else if (tick && !one_shot)
         out_q <= 1'b1;
   end
endmodule // down_counter

// File: far_side_model.sv
// Connector-side model: group B timebases, gates and the external update strobe
module far_side_model #(
   parameter int PIN_HALF_NS = 200
) (
   // Group B pins
   output logic [2:0] group_b_gate_pin,
   output logic       group_b_counter1_clock_pin,
   output logic       group_b_counter2_clock_pin,
   // Update strobe
   output logic       external_update_strobe_n
);
   timeunit 1ns;
   timeprecision 1ps;

   // Gates open, strobe idle high
   initial begin
      group_b_gate_pin = 3'b111;
      external_update_strobe_n = 1'b1;
   end

   // Free-running external timebases, unrelated in phase to clk
   initial begin
      group_b_counter1_clock_pin = 1'b0;
      #7;
      forever #PIN_HALF_NS group_b_counter1_clock_pin = ~group_b_counter1_clock_pin;
   end

   initial begin
      group_b_counter2_clock_pin = 1'b0;
      #13;
      forever #(PIN_HALF_NS * 3) group_b_counter2_clock_pin = ~group_b_counter2_clock_pin;
   end

   // Active-low update pulse, well above the sync window
   task automatic pulse_update();
      #3 external_update_strobe_n = 1'b0;
      #200 external_update_strobe_n = 1'b1;
   endtask
endmodule // far_side_model
